// file: rtl/spwm_pkg.sv
// Constants, register map and field layout of the standard pulse generator
// Operation
// - Time base is the 8-bit timer count with two low sub-count bits appended.
// - With prescale 1:1 the two low bits come from the system-clock phase.
// - The increment after count equals period match clears the count to zero.
// - Each period start sets the output high, unless the duty value is zero.
// - Each period start copies written duty into the active high and low latch.
// - Duty is ten bits: eight in duty high write, two in control bits 5:4.
// - Duty writes are taken anytime but act only at the next period boundary.
// - In pulse mode the active duty high register ignores software writes.
// - Active high register plus two-bit latch double-buffer the duty value.
// - Time base equal to buffered duty clears the output until next start.
// - Period is (match+1) times 4 clocks times the prescale ratio.
// - The postscaler has no effect on the pulse period.
// - Duty above the period gives no match; output stays high all period.
// - Resolution is log2(4*(match+1)) bits, ten bits at match 255.
// - Prescale select offers division by 1, 4 and 16.
// - Timer match flag sets each time the timer completes a period.
// - With the clock halted count, state and output level all freeze.
// - Any reset restores all registers and puts the pin in input direction.
// - Mode select 0000 turns the module off and resets it; 11xx is pulse mode.
// - Clearing the whole control register releases control of the output pin.
package spwm_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] SPWM_OFS_CONTROL = 8'h00;
  localparam logic [7:0] SPWM_OFS_PERIOD = 8'h04;
  localparam logic [7:0] SPWM_OFS_TCTRL = 8'h08;
  localparam logic [7:0] SPWM_OFS_COUNT = 8'h0C;
  localparam logic [7:0] SPWM_OFS_DUTY_WR = 8'h10;
  localparam logic [7:0] SPWM_OFS_DUTY_ACT = 8'h14;
  localparam logic [7:0] SPWM_OFS_FLAG = 8'h18;
  localparam logic [7:0] SPWM_OFS_DIR = 8'h1C;
  // ------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------
  localparam int SPWM_CTL_MODE_LSB = 0;
  localparam int SPWM_CTL_DLOW_LSB = 4;
  localparam int SPWM_TC_PS_LSB = 0;
  localparam int SPWM_TC_RUN_BIT = 2;
  localparam int SPWM_TC_POST_LSB = 3;
  localparam logic [3:0] SPWM_MODE_OFF = 4'h0;
  localparam logic [1:0] SPWM_MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] SPWM_PS_DIV1 = 2'h0;
  localparam logic [1:0] SPWM_PS_DIV4 = 2'h1;
  localparam logic [5:0] SPWM_CTL_MASK = 6'h3F;
  localparam logic [6:0] SPWM_TC_MASK = 7'h7F;
  localparam logic [7:0] SPWM_RST_BYTE = 8'h00;
  localparam logic [7:0] SPWM_PERIOD_RST = 8'hFF;
  localparam logic [1:0] SPWM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SPWM_HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {SPWM_PS_1, SPWM_PS_4, SPWM_PS_16} spwm_ps_t;
endpackage

// file: rtl/spwm_top.sv
// Standard pulse-width generator with an AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module spwm_top
  import spwm_pkg::*;
(
  input wire logic CLK_I, // System clock, 100 MHz
  input wire logic SRST_I, // Synchronous reset, active high
  input wire logic HSEL_I, // Slave select
  input wire logic [31:0] HADDR_I, // Byte address
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write when high
  input wire logic [2:0] HSIZE_I, // Transfer size
  input wire logic [31:0] HWDATA_I, // Write data
  input wire logic HREADY_I, // Bus ready in
  output logic [31:0] HRDATA_O, // Read data
  output logic HREADYOUT_O, // Slave ready
  output logic HRESP_O, // Always OKAY
  output logic PWM_O, // Pulse output level
  output logic PWM_OE_O // Pin driver enable, high drives
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [5:0] control;
  logic [7:0] period_match_value;
  logic [6:0] timer_control;
  logic [7:0] timer_count;
  logic [7:0] duty_high_write;
  logic [7:0] duty_high_active;
  logic [1:0] duty_low_latch;
  logic timer_match_flag;
  logic pin_direction;
  logic [3:0] sub_count;
  logic pwm_level;
  logic pwm_oe;
  logic [31:0] rdata;
  logic wr_pend;
  logic [7:0] wr_addr;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire addr_ok = HSEL_I && HREADY_I && (HTRANS_I == SPWM_HTRANS_NONSEQ)
                 && (HSIZE_I == SPWM_HSIZE_WORD);
  wire rd_take = addr_ok && !HWRITE_I;
  wire wr_take = addr_ok && HWRITE_I;
  wire [7:0] bus_byte = HWDATA_I[7:0];

  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction

  wire wr_ctl = wr_hit(wr_pend, wr_addr, SPWM_OFS_CONTROL);
  wire wr_per = wr_hit(wr_pend, wr_addr, SPWM_OFS_PERIOD);
  wire wr_tc = wr_hit(wr_pend, wr_addr, SPWM_OFS_TCTRL);
  wire wr_cnt = wr_hit(wr_pend, wr_addr, SPWM_OFS_COUNT);
  wire wr_dw = wr_hit(wr_pend, wr_addr, SPWM_OFS_DUTY_WR);
  wire wr_da = wr_hit(wr_pend, wr_addr, SPWM_OFS_DUTY_ACT);
  wire wr_flg = wr_hit(wr_pend, wr_addr, SPWM_OFS_FLAG);
  wire wr_dir = wr_hit(wr_pend, wr_addr, SPWM_OFS_DIR);

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire [3:0] mode_select = control[SPWM_CTL_MODE_LSB +: 4];
  wire [1:0] duty_low_bits = control[SPWM_CTL_DLOW_LSB +: 2];
  wire [1:0] prescale_select = timer_control[SPWM_TC_PS_LSB +: 2];
  wire timer_run = timer_control[SPWM_TC_RUN_BIT];
  // Postscale field is stored for software only; it never reaches the period
  wire [3:0] postscale_select = timer_control[SPWM_TC_POST_LSB +: 4];
  wire pwm_mode = (mode_select[3:2] == SPWM_MODE_PWM_TOP);
  wire module_off = (mode_select == SPWM_MODE_OFF);
  wire control_clear = (control == 6'h00);

  // Prescale ratio selection: 1, 4 or 16 (value 3 acts as 16)
  wire spwm_ps_t ps_sel = (prescale_select == SPWM_PS_DIV1) ? SPWM_PS_1 :
                          (prescale_select == SPWM_PS_DIV4) ? SPWM_PS_4 : SPWM_PS_16;

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  // Sub-count runs at one step per clock; the prescaler stretches each
  // quarter of a timer tick by 1, 4 or 16 clocks, giving the period length
  logic [3:0] ps_last;
  always_comb begin
    case (ps_sel)
      SPWM_PS_1: ps_last = 4'h0;
      SPWM_PS_4: ps_last = 4'h3;
      default: ps_last = 4'hF;
    endcase
  end
  logic [5:0] phase;
  wire [5:0] phase_last = {ps_last, 2'h3};
  // The two low time-base bits are the clock phase at 1:1, else the prescaler top bits
  wire [1:0] tb_low = (ps_sel == SPWM_PS_1) ? phase[1:0] :
                      (ps_sel == SPWM_PS_4) ? phase[3:2] : phase[5:4];
  wire [9:0] time_base = {timer_count, tb_low};
  // A quarter step happens when the low bits change, so compare is per increment
  wire [5:0] q_mask = (ps_sel == SPWM_PS_1) ? 6'h00 :
                      (ps_sel == SPWM_PS_4) ? 6'h03 : 6'h0F;
  // Last clock of a quarter step: the time base moves on at the next edge
  wire tb_step = timer_run && ((phase & q_mask) == q_mask);
  // The level is a flop, so it compares the next time base against duty;
  // the pin then drops exactly when the time base reaches the duty value
  wire [9:0] time_base_next = time_base + 10'h001;
  wire tick = timer_run && (phase == phase_last);
  wire period_end = tick && (timer_count == period_match_value);
  wire [9:0] duty_active = {duty_high_active, duty_low_latch};
  wire [9:0] duty_written = {duty_high_write, duty_low_bits};
  wire duty_match = tb_step && (time_base_next == duty_active);
  wire [7:0] next_count = period_end ? 8'h00 : (timer_count + 8'h01);

  // Prescale phase counter; wraps at the last phase of a timer tick
  always_ff @(posedge CLK_I) begin
    if (SRST_I || !timer_run || wr_tc || wr_cnt) begin
      phase <= 6'h00;
    end else begin
      phase <= tick ? 6'h00 : (phase + 6'h01);
    end
  end

  // Timer count; freezes with the clock when the system sleeps
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      timer_count <= SPWM_RST_BYTE;
    end else if (wr_cnt) begin
      timer_count <= bus_byte;
    end else if (tick) begin
      timer_count <= next_count;
    end
  end

  // Double buffer: the written duty moves to the active copy only at a period start
  always_ff @(posedge CLK_I) begin
    if (SRST_I || module_off) begin
      duty_high_active <= SPWM_RST_BYTE;
      duty_low_latch <= 2'h0;
    end else if (pwm_mode && period_end) begin
      duty_high_active <= duty_high_write;
      duty_low_latch <= duty_low_bits;
    end else if (wr_da && !pwm_mode) begin
      duty_high_active <= bus_byte;
    end
  end

  // Output level: set at period start, cleared on duty match. A duty beyond
  // the period simply never matches, so the level stays high
  always_ff @(posedge CLK_I) begin
    if (SRST_I || !pwm_mode) begin
      pwm_level <= 1'b0;
    end else if (period_end) begin
      pwm_level <= (duty_written != 10'h000);
    end else if (duty_match) begin
      pwm_level <= 1'b0;
    end
  end

  // Pin driver: enabled only when the direction allows and the module owns it
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pwm_oe <= 1'b0;
    end else begin
      pwm_oe <= pin_direction && !control_clear && pwm_mode;
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      control <= SPWM_CTL_MASK & 6'h00;
      period_match_value <= SPWM_PERIOD_RST;
      timer_control <= SPWM_TC_MASK & 7'h00;
      duty_high_write <= SPWM_RST_BYTE;
      pin_direction <= 1'b0;
    end else begin
      if (wr_ctl) begin
        control <= bus_byte[5:0];
      end
      if (wr_per) begin
        period_match_value <= bus_byte;
      end
      if (wr_tc) begin
        timer_control <= bus_byte[6:0];
      end
      if (wr_dw) begin
        duty_high_write <= bus_byte;
      end
      if (wr_dir) begin
        pin_direction <= bus_byte[0];
      end
    end
  end

  // Match flag: a period end in the same cycle as a clear keeps it set
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      timer_match_flag <= 1'b0;
    end else if (period_end) begin
      timer_match_flag <= 1'b1;
    end else if (wr_flg && bus_byte[0]) begin
      timer_match_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave: zero wait states, reads captured in the address phase
  // ------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR_I[7:0])
      SPWM_OFS_CONTROL: next_rdata = {26'h0, control};
      SPWM_OFS_PERIOD: next_rdata = {24'h0, period_match_value};
      SPWM_OFS_TCTRL: next_rdata = {25'h0, postscale_select, timer_control[2:0]};
      SPWM_OFS_COUNT: next_rdata = {24'h0, timer_count};
      SPWM_OFS_DUTY_WR: next_rdata = {24'h0, duty_high_write};
      SPWM_OFS_DUTY_ACT: next_rdata = {24'h0, duty_high_active};
      SPWM_OFS_FLAG: next_rdata = {31'h0, timer_match_flag};
      SPWM_OFS_DIR: next_rdata = {31'h0, pin_direction};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_take && (HADDR_I[31:8] == 24'h0);
      wr_addr <= HADDR_I[7:0];
      rdata <= (rd_take && (HADDR_I[31:8] == 24'h0)) ? next_rdata : 32'h0000_0000;
    end
  end

  assign HRDATA_O = rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign PWM_O = pwm_level;
  assign PWM_OE_O = pwm_oe;

endmodule

// file: tb/spwm_asserts.sv
// Port-level checks of the pulse generator and its register slave
`timescale 1ns/1ps
module spwm_asserts
  import spwm_pkg::*;
(
  input wire logic CLK_I, // System clock
  input wire logic SRST_I, // Synchronous reset
  input wire logic HSEL_I, // Slave select
  input wire logic [31:0] HADDR_I, // Byte address
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write when high
  input wire logic [2:0] HSIZE_I, // Transfer size
  input wire logic [31:0] HWDATA_I, // Write data
  input wire logic HREADY_I, // Bus ready in
  input wire logic [31:0] HRDATA_O, // Read data
  input wire logic HREADYOUT_O, // Slave ready
  input wire logic HRESP_O, // Response
  input wire logic PWM_O, // Pulse level
  input wire logic PWM_OE_O // Pin driver enable
);
  // ------------------------------------------------------------
  // Data phase tracking
  // ------------------------------------------------------------
  wire take = HSEL_I && HREADY_I && (HTRANS_I == SPWM_HTRANS_NONSEQ);
  wire bad_addr = (HADDR_I[31:8] != 24'h0) || (HADDR_I[7:0] > 8'h1C) || (HSIZE_I != SPWM_HSIZE_WORD);
  logic rd_ph, bad_ph, ctl_ph;
  // Reset folded in so each phase flag is one line
  always_ff @(posedge CLK_I) begin
    rd_ph <= !SRST_I && take && !HWRITE_I;
    bad_ph <= !SRST_I && take && !HWRITE_I && bad_addr;
    ctl_ph <= !SRST_I && take && HWRITE_I && !bad_addr && (HADDR_I[7:0] == SPWM_OFS_CONTROL);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  ready_const_a: assert property (HREADYOUT_O) else $error("slave stalled");
  resp_okay_a: assert property (!HRESP_O) else $error("error response");
  rst_quiet_a: assert property ($fell(SRST_I) |-> HRDATA_O == 32'h0 && !PWM_O && !PWM_OE_O)
    else $error("outputs not cleared by reset");
  idle_zero_a: assert property (!rd_ph |-> HRDATA_O == 32'h0) else $error("read data outside phase");
  upper_zero_a: assert property (HRDATA_O[31:8] == 24'h0) else $error("upper read bits set");
  unmapped_zero_a: assert property (bad_ph |-> HRDATA_O == 32'h0) else $error("refused read not 0");
  ctl_release_a: assert property (ctl_ph && HWDATA_I[7:0] == 8'h00 |-> ##[1:3] !PWM_OE_O && !PWM_O)
    else $error("pin kept after control clear");
  rise_spacing_a: assert property ($rose(PWM_O) |=> !$rose(PWM_O) [*3])
    else $error("period shorter than four clocks");
  cover property (rd_ph);
  cover property ($rose(PWM_O) && PWM_OE_O);
  cover property (ctl_ph && HWDATA_I[7:0] == 8'h00);
endmodule
bind spwm_top spwm_asserts chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
  .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .PWM_O(PWM_O), .PWM_OE_O(PWM_OE_O));

// file: tb/spwm_load.sv
// Load on the pulse pin: measures high time and period of each pulse
`timescale 1ns/1ps
module spwm_load (
  input wire logic clk_i, // System clock
  input wire logic pwm_i, // Pulse level
  input wire logic pwm_oe_i, // Pin driver enable
  output logic [31:0] meas_o, // High cycles and period cycles
  output logic meas_stb_o // New measurement
);
  logic lvl_q;
  logic [15:0] hi_cnt, per_cnt;
  // Released pin sits at the pull-down, so no stale high is seen
  wire lvl = pwm_oe_i ? pwm_i : 1'b0;
  // A rising edge closes one period and opens the next
  always_ff @(posedge clk_i) begin
    lvl_q <= lvl;
    meas_stb_o <= lvl && !lvl_q;
    if (lvl && !lvl_q) begin
      meas_o <= {hi_cnt, per_cnt};
      hi_cnt <= 16'h1;
      per_cnt <= 16'h1;
    end else begin
      per_cnt <= per_cnt + 16'h1;
      hi_cnt <= hi_cnt + {15'h0, lvl};
    end
  end
endmodule

// file: tb/spwm_top_tb.sv
// Self-checking bench of the pulse generator over its register bus
`timescale 1ns/1ps
module spwm_top_tb import spwm_pkg::*;;
  typedef struct {logic [31:0] v; string n;} spwm_note_t;
  logic CLK_I = 1'b0, SRST_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0, rd_ph = 1'b0, arm = 1'b0;
  logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, meas, seed = 32'h3B6B7301;
  logic [1:0] HTRANS_I = 2'h0;
  logic [2:0] HSIZE_I = SPWM_HSIZE_WORD;
  logic HREADYOUT_O, HRESP_O, PWM_O, PWM_OE_O, meas_stb;
  wire HREADY_I = HREADYOUT_O;
  int err_total = 0, n_compared = 0;
  spwm_note_t q[$], e;
  always #5 CLK_I = ~CLK_I;
  spwm_top dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .PWM_O(PWM_O), .PWM_OE_O(PWM_OE_O));
  spwm_load load (.clk_i(CLK_I), .pwm_i(PWM_O), .pwm_oe_i(PWM_OE_O), .meas_o(meas),
    .meas_stb_o(meas_stb));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Single word transfer; d is write data, or the expected word of a read
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input string n);
    HSEL_I <= 1'b1;
    HTRANS_I <= SPWM_HTRANS_NONSEQ;
    HADDR_I <= {24'h0, a};
    HWRITE_I <= w;
    do @(posedge CLK_I); while (HREADY_I !== 1'b1);
    HTRANS_I <= 2'h0;
    HWDATA_I <= w ? d : 32'h0;
    if (!w) begin
      q.push_back('{d, n});
      rd_ph <= 1'b1;
    end
    do @(posedge CLK_I); while (HREADY_I !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  // Oldest note against each read word or armed pulse measurement
  always @(posedge CLK_I) begin
    if (rd_ph || (arm && meas_stb === 1'b1)) begin
      e = q.pop_front();
      check(e.n, rd_ph ? HRDATA_O : meas, e.v);
      arm <= 1'b0;
    end
  end
  // Hang guard; the whole run needs under a thousand cycles
  initial begin
    repeat (10000) @(posedge CLK_I);
    err_total++;
    results();
  end
  initial begin
    logic [7:0] per;
    logic [9:0] duty;
    int ratio;
    repeat (12) @(posedge CLK_I);
    SRST_I <= 1'b0;
    for (int i = 0; i < 9; i++) xfer(1'b0, 8'(4 * i), (i == 1) ? 32'hFF : 32'h0, "reset");
    xfer(1'b1, SPWM_OFS_CONTROL, 32'hFFFF_FFF0, "");
    xfer(1'b0, SPWM_OFS_CONTROL, 32'h30, "control");
    // Every prescale code, with random duty inside the period
    for (int k = 0; k < 4; k++) begin
      ratio = (k == 0) ? 1 : (k == 1) ? 4 : 16;
      per = (k == 0) ? 8'h03 : (k == 1) ? 8'h01 : 8'h00;
      seed = xorshift(seed);
      duty = 10'(1 + seed % (4 * per + 3));
      xfer(1'b1, SPWM_OFS_DIR, 32'h0, "");
      xfer(1'b1, SPWM_OFS_CONTROL, 32'h0, "");
      xfer(1'b1, SPWM_OFS_TCTRL, 32'h0, "");
      xfer(1'b1, SPWM_OFS_PERIOD, {24'h0, per}, "");
      xfer(1'b1, SPWM_OFS_CONTROL, {26'h0, duty[1:0], 2'b11, 2'(k)}, "");
      xfer(1'b1, SPWM_OFS_DUTY_WR, {24'h0, duty[9:2]}, "");
      xfer(1'b1, SPWM_OFS_FLAG, 32'h1, "");
      xfer(1'b1, SPWM_OFS_COUNT, 32'h0, "");
      xfer(1'b1, SPWM_OFS_TCTRL, {25'h0, 4'hF, 1'b1, 2'(k)}, "");
      repeat (4 * (per + 1) * ratio + 4) @(posedge CLK_I);
      xfer(1'b0, SPWM_OFS_FLAG, 32'h1, "match flag");
      xfer(1'b1, SPWM_OFS_DIR, 32'h1, "");
      repeat (8 * (per + 1) * ratio) @(posedge CLK_I);
      q.push_back('{{16'(duty * ratio), 16'(4 * (per + 1) * ratio)}, "pulse"});
      arm <= 1'b1;
      do @(posedge CLK_I); while (arm);
      xfer(1'b1, SPWM_OFS_DUTY_ACT, {24'h0, ~duty[9:2]}, "");
      xfer(1'b0, SPWM_OFS_DUTY_ACT, {24'h0, duty[9:2]}, "active duty");
    end
    results();
  end
endmodule
